/* File: rtl/wcba_counters.sv */
// word count / bus address counter slice with shared three-state bus
// assumes all strobes, counter clocks and bus data come from pins
`timescale 1ns/1ps
module wcba_counters
  import wcba_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // control strobes
  input  wire logic       clear,
  input  wire logic       load_strobe,
  input  wire logic       read_strobe,
  input  wire logic       sel_count,
  input  wire logic       sel_addr,
  input  wire logic       address_step_size_select,
  // counter clocks
  input  wire logic       count_clk,
  input  wire logic       addr_clk,
  // three-state bus
  input  wire logic [7:0] bus_in,
  output logic [7:0]      bus_out,
  output logic            bus_oe,
  // cascade carries
  output logic            count_reached_zero,
  output logic            addr_carry
);
  wcba_pins_s  raw;
  wcba_pins_s  pin;
  logic [WCBA_PINS_W-1:0] pin_q;

  logic [7:0]  transfer_count;
  logic [7:0]  addr;
  logic        count_clk_d;
  logic        addr_clk_d;

  assign raw = '{clear: clear, load_strobe: load_strobe, read_strobe: read_strobe,
                 sel_count: sel_count, sel_addr: sel_addr,
                 address_step_size_select: address_step_size_select,
                 count_clk: count_clk, addr_clk: addr_clk, bus_in: bus_in};

  wcba_sync #(.W(WCBA_PINS_W)) u_sync (
    .clk     (clk_sys),
    .reset_n (reset_n),
    .d       (raw),
    .q       (pin_q)
  );
  assign pin = wcba_pins_s'(pin_q);

  // rising edge of a filtered level against its copy from the last cycle
  function automatic logic rise(input logic now_lvl, input logic was_lvl);
    return now_lvl & ~was_lvl;
  endfunction

  // clear over load over increment, shared by both counters
  function automatic logic [7:0] pick_value(
    input logic       zap,
    input logic       take,
    input logic       inc,
    input logic [7:0] bus_v,
    input logic [7:0] sum,
    input logic [7:0] keep
  );
    logic [7:0] v;
    v = keep;
    if (zap) begin
      v = WCBA_ZERO;
    end else if (take) begin
      v = bus_v;
    end else if (inc) begin
      v = sum;
    end
    return v;
  endfunction

  // carry clears on clear or load, follows a step, otherwise stands
  function automatic logic pick_carry(
    input logic zap,
    input logic take,
    input logic inc,
    input logic wrap,
    input logic keep
  );
    logic c;
    c = keep;
    if (zap | take) begin
      c = 1'b0;
    end else if (inc) begin
      c = wrap;
    end
    return c;
  endfunction

  // decode
  wire       count_edge = rise(pin.count_clk, count_clk_d);
  wire       addr_edge  = rise(pin.addr_clk, addr_clk_d);
  wire       count_load = pin.load_strobe & pin.sel_count;
  wire       addr_load  = pin.load_strobe & pin.sel_addr;
  wire       count_rd   = pin.read_strobe & pin.sel_count;
  wire       addr_rd    = pin.read_strobe & pin.sel_addr;
  wire [8:0] count_sum  = {1'b0, transfer_count} + WCBA_SUM_ONE;
  wire [8:0] addr_sum   = {1'b0, addr}
                          + (pin.address_step_size_select ? WCBA_SUM_TWO : WCBA_SUM_ONE);

  wire       addr_change = addr_edge | addr_load | pin.clear;

  // clear over load over increment
  wire [7:0] next_count = pick_value(pin.clear, count_load, count_edge,
                                     pin.bus_in, count_sum[7:0], transfer_count);
  wire [7:0] next_addr  = pick_value(pin.clear, addr_load, addr_edge,
                                     pin.bus_in, addr_sum[7:0], addr);
  // carry rises on wrap and stands until the counter next changes
  wire       next_count_carry = pick_carry(pin.clear, count_load, count_edge,
                                           count_sum[8], count_reached_zero);
  wire       next_addr_carry  = pick_carry(pin.clear, addr_load, addr_edge,
                                           addr_sum[8], addr_carry);
  wire       next_oe  = count_rd | addr_rd;
  wire [7:0] next_out = count_rd ? transfer_count : addr_rd ? addr : bus_out;

  // counters and their carries
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      transfer_count     <= WCBA_ZERO;
      addr               <= WCBA_ZERO;
      count_reached_zero <= 1'b0;
      addr_carry         <= 1'b0;
    end else begin
      transfer_count     <= next_count;
      addr               <= next_addr;
      count_reached_zero <= next_count_carry;
      addr_carry         <= next_addr_carry;
    end
  end

  // clock-level history for edge detection, and the bus drivers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_clk_d <= 1'b0;
      addr_clk_d  <= 1'b0;
      bus_oe      <= 1'b0;
      bus_out     <= WCBA_ZERO;
    end else begin
      count_clk_d <= pin.count_clk;
      addr_clk_d  <= pin.addr_clk;
      bus_oe      <= next_oe;
      bus_out     <= next_out;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_clear_zeroes: assert property (pin.clear |=> transfer_count == WCBA_ZERO
    && addr == WCBA_ZERO && !count_reached_zero && !addr_carry)
    else $error("clear did not zero both counters");
  a_load_count: assert property (count_load && !pin.clear
    |=> transfer_count == $past(pin.bus_in))
    else $error("count load missed bus value");
  a_load_needs_sel: assert property (!pin.sel_addr && !addr_edge && !pin.clear
    |=> addr == $past(addr))
    else $error("address changed without select or clock");
  a_count_step: assert property (count_edge && !count_load && !pin.clear
    |=> transfer_count == 8'($past(transfer_count) + WCBA_STEP_BYTE))
    else $error("count did not step by one");
  a_addr_step: assert property (addr_edge && !addr_load && !pin.clear
    |=> addr == 8'($past(addr) + ($past(pin.address_step_size_select)
                                  ? WCBA_STEP_WORD : WCBA_STEP_BYTE)))
    else $error("address step size wrong");
  a_count_isolated: assert property (!count_edge && !count_load && !pin.clear
    |=> $stable(transfer_count))
    else $error("count moved without its own clock");
  a_wrap_carry: assert property (count_edge && transfer_count == 8'hFF
    && !count_load && !pin.clear |=> transfer_count == WCBA_ZERO && count_reached_zero)
    else $error("count wrap did not raise carry");
  a_addr_carry: assert property (addr_edge && addr_sum[8] && !addr_load && !pin.clear
    |=> addr_carry ##1 (addr_carry || $past(addr_change)))
    else $error("address carry missing on overflow");
  a_clear_wins: assert property (pin.clear && count_load && count_edge
    |=> transfer_count == WCBA_ZERO)
    else $error("clear lost to load");
  a_bus_drive: assert property (count_rd |=> bus_oe && bus_out == $past(transfer_count))
    else $error("read did not drive count");
  a_bus_release: assert property (!pin.read_strobe |=> !bus_oe)
    else $error("bus driven without read");

  // address side, count select, carry, priority and bus enable checks
  a_load_addr: assert property (addr_load && !pin.clear
    |=> addr == $past(pin.bus_in))
    else $error("address load missed bus value");
  a_count_needs_sel: assert property (!pin.sel_count && !count_edge && !pin.clear
    |=> $stable(transfer_count))
    else $error("count changed without select or clock");
  a_addr_isolated: assert property (!addr_edge && !addr_load && !pin.clear
    |=> $stable(addr))
    else $error("address moved without its own clock");
  a_addr_wrap: assert property (addr_edge && addr == 8'hFF && !addr_load && !pin.clear
    |=> addr_carry
        && addr == ($past(pin.address_step_size_select) ? WCBA_STEP_BYTE : WCBA_ZERO))
    else $error("address wrap wrong");
  a_early_carry: assert property (count_edge && transfer_count != 8'hFF
    && !count_load && !pin.clear |=> !count_reached_zero)
    else $error("count carry without wrap");
  a_count_carry_hold: assert property (count_reached_zero && !count_edge && !count_load
    && !pin.clear |=> count_reached_zero)
    else $error("count carry dropped early");
  a_addr_carry_hold: assert property (addr_carry && !addr_change |=> addr_carry)
    else $error("address carry dropped early");
  a_load_over_step: assert property (count_load && count_edge && !pin.clear
    |=> transfer_count == $past(pin.bus_in))
    else $error("count step beat load");
  a_addr_clear_wins: assert property (pin.clear && addr_load && addr_edge
    |=> addr == WCBA_ZERO && !addr_carry)
    else $error("clear lost on address");
  a_bus_drive_addr: assert property (addr_rd && !pin.sel_count
    |=> bus_oe && bus_out == $past(addr))
    else $error("read did not drive address");
  a_oe_needs_read: assert property (!count_rd && !addr_rd |=> !bus_oe)
    else $error("bus driven without select");

  c_count_wrap: cover property (count_edge && transfer_count == 8'hFF);
  c_word_step:  cover property (addr_edge && pin.address_step_size_select);
  c_read_addr:  cover property (addr_rd && !pin.sel_count);
  c_load_then_step: cover property (count_load ##[1:100] count_edge);
  c_clear_all:  cover property (pin.clear && count_load && count_edge);
endmodule

/* File: shared/wcba_pkg.sv */
// constants and carriers for the word count / bus address counter slice
// assumes every control pin arrives asynchronously to clk_sys
// Summary of operation
// - two independent 8-bit up-counters: count, address
// - carry outputs let two slices cascade
// - clear zeroes both counters together
// - load needs load strobe plus counter select
// - each counter steps only on its clock
// - count counter always steps by one
// - address steps one or two by select
// - bus driven only on read plus select
// - overflow raises carry to clock next slice
package wcba_pkg;
  localparam int          WCBA_W          = 8;
  localparam logic [7:0]  WCBA_ZERO       = 8'h00;
  localparam logic [7:0]  WCBA_STEP_BYTE  = 8'h01;
  localparam logic [7:0]  WCBA_STEP_WORD  = 8'h02;
  localparam logic [8:0]  WCBA_SUM_ONE    = 9'h001;
  localparam logic [8:0]  WCBA_SUM_TWO    = 9'h002;

  typedef struct packed {
    logic       clear;
    logic       load_strobe;
    logic       read_strobe;
    logic       sel_count;
    logic       sel_addr;
    logic       address_step_size_select;
    logic       count_clk;
    logic       addr_clk;
    logic [7:0] bus_in;
  } wcba_pins_s;

  localparam int          WCBA_PINS_W     = $bits(wcba_pins_s);
endpackage

/* File: rtl/wcba_sync.sv */
// three-stage pin synchroniser with agreement filter
// assumes inputs are asynchronous to clk
`timescale 1ns/1ps
module wcba_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // raw and filtered levels
  input  wire logic [W-1:0] d,
  output logic [W-1:0]      q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] agree;
  logic [W-1:0] next_q;

  // a bit changes only once stages two and three agree
  assign agree  = ~(s2 ^ s3);
  assign next_q = (agree & s3) | (~agree & q);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q  <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q  <= next_q;
    end
  end
endmodule

/* File: dv/wcba_ctrl_model.sv */
// controller model: drives the slice's control pins and its bus side
// assumes the bench calls drive() and samples outputs when it returns
`timescale 1ns/1ps
module wcba_ctrl_model
  import wcba_pkg::*;
(
  // clock
  input  wire logic clk_sys,
  // pins toward the slice
  output wcba_pins_s pins
);
  initial pins = '0;

  // released bus shows the inverse of its last value, never a stale copy
  task automatic drive(input logic [7:0] ctl, input logic [7:0] d);
    @(negedge clk_sys);
    pins = {ctl, (ctl[6] ? d : ~pins.bus_in)};
    repeat (8) @(negedge clk_sys);
  endtask
endmodule

/* File: dv/wcba_counters_tb.sv */
// self-checking bench for the counter slice
// assumes the controller model drives every pin at the falling edge
`timescale 1ns/1ps
module wcba_counters_tb import wcba_pkg::*;;
  localparam logic [7:0] CLR = 8'h80, LOAD = 8'h40, RD = 8'h20, SC = 8'h10;
  localparam logic [7:0] SA = 8'h08, ST = 8'h04, CK = 8'h02, AK = 8'h01;
  logic       clk_sys;
  logic       reset_n;
  wcba_pins_s pins;
  logic [7:0] bus_out;
  logic       bus_oe;
  logic       count_reached_zero;
  logic       addr_carry;
  int         fails;
  int         check_count;

  wcba_ctrl_model ctrl_u (.clk_sys(clk_sys), .pins(pins));
  wcba_counters dut_u (
    .clk_sys(clk_sys), .reset_n(reset_n), .clear(pins.clear),
    .load_strobe(pins.load_strobe), .read_strobe(pins.read_strobe),
    .sel_count(pins.sel_count), .sel_addr(pins.sel_addr),
    .address_step_size_select(pins.address_step_size_select),
    .count_clk(pins.count_clk), .addr_clk(pins.addr_clk),
    .bus_in(bus_oe ? bus_out : pins.bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
    .count_reached_zero(count_reached_zero), .addr_carry(addr_carry)
  );

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rd(input logic [7:0] sel, input logic [7:0] exp);
    ctrl_u.drive(RD | sel, 8'h00);
    chk("bus_oe", {7'h00, bus_oe}, 8'h01);
    chk("bus_out", bus_out, exp);
    ctrl_u.drive(8'h00, 8'h00);
    chk("bus_oe idle", {7'h00, bus_oe}, 8'h00);
  endtask

  task automatic put(input logic [7:0] sel, input logic [7:0] v);
    ctrl_u.drive(LOAD | sel, v);
    ctrl_u.drive(8'h00, 8'h00);
  endtask

  task automatic t_load_read();
    put(SC, 8'hFE);
    put(SA, 8'h10);
    rd(SC, 8'hFE);
    rd(SA, 8'h10);
    rd(SC | SA, 8'hFE);
  endtask

  task automatic t_count_wrap();
    ctrl_u.drive(CK, 8'h00);
    ctrl_u.drive(8'h00, 8'h00);
    rd(SC, 8'hFF);
    chk("count carry", {7'h00, count_reached_zero}, 8'h00);
    ctrl_u.drive(CK, 8'h00);
    ctrl_u.drive(8'h00, 8'h00);
    rd(SC, 8'h00);
    chk("count carry", {7'h00, count_reached_zero}, 8'h01);
    rd(SA, 8'h10);
  endtask

  task automatic t_addr_step();
    ctrl_u.drive(AK, 8'h00);
    ctrl_u.drive(8'h00, 8'h00);
    rd(SA, 8'h11);
    ctrl_u.drive(ST | AK, 8'h00);
    ctrl_u.drive(ST, 8'h00);
    rd(SA, 8'h13);
    put(SA, 8'hFE);
    ctrl_u.drive(ST | AK, 8'h00);
    ctrl_u.drive(8'h00, 8'h00);
    rd(SA, 8'h00);
    chk("addr carry", {7'h00, addr_carry}, 8'h01);
    rd(SC, 8'h00);
  endtask

  task automatic t_refuse_clear();
    put(8'h00, 8'h55);
    rd(SC, 8'h00);
    rd(SA, 8'h00);
    put(SA, 8'hFF);
    ctrl_u.drive(ST | AK, 8'h00);
    ctrl_u.drive(8'h00, 8'h00);
    rd(SA, 8'h01);
    chk("addr carry", {7'h00, addr_carry}, 8'h01);
    ctrl_u.drive(CLR | LOAD | SA | SC | CK | AK, 8'h77);
    ctrl_u.drive(8'h00, 8'h00);
    rd(SA, 8'h00);
    chk("carries", {6'h00, addr_carry, count_reached_zero}, 8'h00);
    ctrl_u.drive(LOAD | SC | CK, 8'h42);
    ctrl_u.drive(8'h00, 8'h00);
    rd(SC, 8'h42);
    ctrl_u.drive(CLR | CK, 8'h00);
    ctrl_u.drive(8'h00, 8'h00);
    rd(SC, 8'h00);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  initial begin
    fails = 0;
    check_count = 0;
    reset_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("reset bus_oe", {7'h00, bus_oe}, 8'h00);
    reset_n = 1'b1;
    t_load_read();
    t_count_wrap();
    t_addr_step();
    t_refuse_clear();
    final_report();
  end
endmodule
